// File: rtl/obma_defs.svh
// constants for the operand bus master and arbitration block
// Behaviour
// - four cycle kinds share one sequence; mem/io and read/write selects differ
// - address phase: grant ack, fetch phase high, address strobe low, controls valid
// - data strobe falls half a period into strobe phase
// - acknowledge sampled each rising edge after data strobe; phase extends until low
// - cycle ends one period after the rising edge seeing acknowledge
// - protect fault or bus error sampled alongside acknowledge ends cycle as error
// - both strobes return high on first rising edge after strobe phase
// - one period later grant ack, controls, address and data float
// - while owning buses for back-to-back cycles, no new request, keep grant ack
// - grant ack released to high impedance, never driven high
// - request asserted at arbitration phase start when cycle needed and not owner
// - grant and busy sampled on falling edges; wait until grant low, busy high
// - grant ack held until release phase of first cycle not keeping buses
// - request, grant, busy and grant ack are all active low
// - address, data and controls driven only while bus master, else floated
// - fetch phase low from execute phase through arbitration phase
`ifndef OBMA_DEFS_SVH
`define OBMA_DEFS_SVH
`define OBMA_ADDR_W 16
`define OBMA_DATA_W 16
`define OBMA_CLK_PERIOD_NS 40
`endif

// File: rtl/obma_pkg.sv
// types for the operand bus master and arbitration block
package obma_pkg;
   typedef enum logic [2:0] {
      OBMA_IDLE, OBMA_ARB, OBMA_ADDR, OBMA_STRB, OBMA_END, OBMA_REL
   } obma_state_t;
   typedef enum logic [1:0] {
      OBMA_MEM_RD, OBMA_MEM_WR, OBMA_IO_RD, OBMA_IO_WR
   } obma_kind_t;
endpackage

// File: rtl/obma_arb_sampler.sv
// falling-edge sampler of grant and busy for arbitration
`timescale 1ns/1ps
`default_nettype none
module obma_arb_sampler (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // arbitration inputs
   input wire logic bus_grant_in_n,
   input wire logic bus_busy_in_n,
   // result
   output logic won_q
);
   wire win_now = !bus_grant_in_n && bus_busy_in_n;

   always_ff @(negedge clock or negedge reset_n) begin
      if (!reset_n) begin
         won_q <= 1'b0;
      end else begin
         won_q <= win_now;
      end
   end
endmodule
`default_nettype wire

// File: rtl/obma_master.sv
// operand bus master with multi-master arbitration
`timescale 1ns/1ps
`default_nettype none
`include "obma_defs.svh"
module obma_master
   import obma_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // core request side
   input wire logic req_valid,
   input wire logic [1:0] req_kind,
   input wire logic req_operand,
   input wire logic req_more,
   input wire logic [`OBMA_ADDR_W-1:0] req_addr,
   input wire logic [`OBMA_DATA_W-1:0] req_wdata,
   output logic req_ready,
   output logic done_pulse,
   output logic error_pulse,
   output logic [`OBMA_DATA_W-1:0] rdata_q,
   // arbitration
   output logic bus_req_out_n,
   input wire logic bus_grant_in_n,
   input wire logic bus_busy_in_n,
   output logic grant_ack_out_n,
   output logic grant_ack_oe,
   // operand bus controls
   output logic fetch_phase_out,
   output logic addr_strobe_n,
   output logic data_strobe_n,
   output logic rd_wr_n,
   output logic mem_io_n,
   output logic operand_or_instr_sel,
   output logic ctrl_oe,
   output logic [`OBMA_ADDR_W-1:0] addr_out,
   output logic addr_oe,
   input wire logic [`OBMA_DATA_W-1:0] data_in,
   output logic [`OBMA_DATA_W-1:0] data_out,
   output logic data_oe,
   // responder status
   input wire logic xfer_ack_n,
   input wire logic mem_protect_fault_n,
   input wire logic bus_error_in_n
);
   obma_state_t state_q, state_d;
   logic owner_q, ds_q, as_q, fetch_q, drive_q, rd_q, mio_q, opsel_q, req_q;
   logic more_q, done_q, err_q;
   logic [`OBMA_ADDR_W-1:0] addr_q;
   logic [`OBMA_DATA_W-1:0] wdata_q;
   logic won_q;

   obma_arb_sampler u_arb (
      .clock(clock),
      .reset_n(reset_n),
      .bus_grant_in_n(bus_grant_in_n),
      .bus_busy_in_n(bus_busy_in_n),
      .won_q(won_q)
   );

   function automatic logic kind_is_read(input logic [1:0] k);
      return (k == OBMA_MEM_RD) || (k == OBMA_IO_RD);
   endfunction
   function automatic logic kind_is_mem(input logic [1:0] k);
      return (k == OBMA_MEM_RD) || (k == OBMA_MEM_WR);
   endfunction

   wire ack_seen = !xfer_ack_n;
   wire err_seen = !mem_protect_fault_n || !bus_error_in_n;
   wire finish = ack_seen || err_seen;
   wire start = req_valid && (state_q == OBMA_IDLE);

   assign req_ready = (state_q == OBMA_IDLE);

   always_comb begin
      state_d = state_q;
      case (state_q)
         OBMA_IDLE: begin
            if (req_valid) begin
               state_d = owner_q ? OBMA_ADDR : OBMA_ARB;
            end
         end
         OBMA_ARB: begin
            if (won_q) begin
               state_d = OBMA_ADDR;
            end
         end
         OBMA_ADDR: state_d = OBMA_STRB;
         OBMA_STRB: begin
            if (ds_q && finish) begin
               state_d = OBMA_END;
            end
         end
         OBMA_END: state_d = OBMA_REL;
         OBMA_REL: state_d = OBMA_IDLE;
         default: state_d = OBMA_IDLE;
      endcase
   end

   // rising-edge sequencer
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= OBMA_IDLE;
         req_q <= 1'b0;
         as_q <= 1'b0;
         fetch_q <= 1'b0;
         drive_q <= 1'b0;
         owner_q <= 1'b0;
         more_q <= 1'b0;
         rd_q <= 1'b1;
         mio_q <= 1'b1;
         opsel_q <= 1'b1;
         addr_q <= '0;
         wdata_q <= '0;
         done_q <= 1'b0;
         err_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         state_q <= state_d;
         done_q <= (state_q == OBMA_STRB) && ds_q && ack_seen && !err_seen;
         err_q <= (state_q == OBMA_STRB) && ds_q && err_seen;
         if (start) begin
            rd_q <= kind_is_read(req_kind);
            mio_q <= kind_is_mem(req_kind);
            opsel_q <= req_operand;
            addr_q <= req_addr;
            wdata_q <= req_wdata;
            more_q <= req_more;
         end
         req_q <= (state_d == OBMA_ARB);
         fetch_q <= (state_d == OBMA_ADDR) || (state_d == OBMA_STRB);
         if (state_d == OBMA_ADDR) begin
            as_q <= 1'b1;
            drive_q <= 1'b1;
            owner_q <= 1'b1;
         end
         if (state_q == OBMA_END) begin
            as_q <= 1'b0;
         end
         if (state_q == OBMA_REL) begin
            drive_q <= 1'b0;
            owner_q <= more_q;
         end
         if (state_q == OBMA_STRB && ds_q && finish && rd_q) begin
            rdata_q <= data_in;
         end
      end
   end

   // falling-edge data strobe
   always_ff @(negedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ds_q <= 1'b0;
      end else if (state_q == OBMA_STRB) begin
         ds_q <= 1'b1;
      end else if (state_q == OBMA_END) begin
         ds_q <= ds_q;
      end else begin
         ds_q <= 1'b0;
      end
   end
   assign bus_req_out_n = !req_q;
   assign grant_ack_out_n = 1'b0;
   assign grant_ack_oe = owner_q;
   assign fetch_phase_out = fetch_q;
   assign addr_strobe_n = !as_q;
   // data strobe released with the address strobe on the rising edge
   assign data_strobe_n = !(ds_q && as_q);
   assign rd_wr_n = rd_q;
   assign mem_io_n = mio_q;
   assign operand_or_instr_sel = opsel_q;
   assign ctrl_oe = drive_q;
   assign addr_out = addr_q;
   assign addr_oe = drive_q;
   assign data_out = wdata_q;
   assign data_oe = drive_q && !rd_q;
   assign done_pulse = done_q;
   assign error_pulse = err_q;

   AST_DS_AFTER_AS: assert property (@(posedge clock) disable iff (!reset_n)
      $fell(addr_strobe_n) |=> ##1 !data_strobe_n)
      else $error("data strobe not low one period after address strobe");
   AST_END_ON_ACK: assert property (@(posedge clock) disable iff (!reset_n)
      (state_q == OBMA_STRB && ds_q && !xfer_ack_n) |=> ##1 addr_strobe_n)
      else $error("strobes not released after acknowledge");
   AST_ERR_END: assert property (@(posedge clock) disable iff (!reset_n)
      (state_q == OBMA_STRB && ds_q && err_seen) |=> error_pulse)
      else $error("error input did not end cycle");
   AST_HOLD_WAIT: assert property (@(posedge clock) disable iff (!reset_n)
      (state_q == OBMA_STRB && ds_q && !finish) |=> !addr_strobe_n)
      else $error("strobe phase not extended without acknowledge");
   AST_FLOAT_REL: assert property (@(posedge clock) disable iff (!reset_n)
      (state_q == OBMA_REL) |=> !addr_oe && !ctrl_oe)
      else $error("buses not floated after cycle");
   AST_NO_REQ_OWNER: assert property (@(posedge clock) disable iff (!reset_n)
      grant_ack_oe |-> bus_req_out_n)
      else $error("request while already owning bus");
   AST_DRIVE_OWNER: assert property (@(posedge clock) disable iff (!reset_n)
      addr_oe |-> grant_ack_oe)
      else $error("bus driven without ownership");
   AST_ARB_WAIT: assert property (@(posedge clock) disable iff (!reset_n)
      (state_q == OBMA_ARB && !won_q) |=> addr_strobe_n)
      else $error("address phase before arbitration won");
   AST_FETCH_ADDR: assert property (@(posedge clock) disable iff (!reset_n)
      $fell(addr_strobe_n) |-> fetch_phase_out && !grant_ack_out_n)
      else $error("address phase signals wrong");
   AST_STROBES_RELEASE: assert property (@(posedge clock) disable iff (!reset_n)
      (state_q == OBMA_END) |=> addr_strobe_n && data_strobe_n)
      else $error("strobes not released after cycle end");
   AST_FETCH_LOW_ARB: assert property (@(posedge clock) disable iff (!reset_n)
      (state_q == OBMA_ARB) |-> !fetch_phase_out)
      else $error("fetch phase high during arbitration");
   COV_READ: cover property (@(posedge clock) disable iff (!reset_n)
      done_pulse && rd_wr_n);
   COV_WRITE: cover property (@(posedge clock) disable iff (!reset_n)
      done_pulse && !rd_wr_n);
   COV_ERR: cover property (@(posedge clock) disable iff (!reset_n) error_pulse);
   COV_OWNED_START: cover property (@(posedge clock) disable iff (!reset_n)
      (state_q == OBMA_IDLE) && req_valid && owner_q);
   COV_ARB_WAIT: cover property (@(posedge clock) disable iff (!reset_n)
      (state_q == OBMA_ARB) [*3]);
endmodule
`default_nettype wire

// File: tb/obma_partner.sv
// responder and arbiter model facing the operand bus master
`timescale 1ns/1ps
`default_nettype none
module obma_partner (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // bench controls
   input wire logic [3:0] waits,
   input wire logic [1:0] err,
   input wire logic other_busy,
   // master side
   input wire logic bus_req_out_n,
   input wire logic data_strobe_n,
   input wire logic rd_wr_n,
   input wire logic [15:0] data_out,
   // responses
   output logic bus_grant_in_n,
   output logic bus_busy_in_n,
   output logic xfer_ack_n,
   output logic mem_protect_fault_n,
   output logic bus_error_in_n,
   output logic [15:0] data_in
);
   logic [3:0] cnt_q;
   logic [15:0] mem_q;
   logic hit;
   assign hit = !data_strobe_n && cnt_q >= waits;
   assign bus_grant_in_n = bus_req_out_n;
   assign bus_busy_in_n = !other_busy;
   assign xfer_ack_n = !(hit && err == 2'h0);
   assign mem_protect_fault_n = !(hit && err == 2'h1);
   assign bus_error_in_n = !(hit && err == 2'h2);
   // released data lines show the inverse of the stored word
   assign data_in = (!data_strobe_n && rd_wr_n) ? mem_q : ~mem_q;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 4'h0;
         mem_q <= 16'h0000;
      end else begin
         cnt_q <= data_strobe_n ? 4'h0 : cnt_q + 4'h1;
         if (!xfer_ack_n && !rd_wr_n) mem_q <= data_out;
      end
   end
endmodule
`default_nettype wire

// File: tb/obma_master_tb.sv
// self-checking bench for the operand bus master
`timescale 1ns/1ps
`default_nettype none
module obma_master_tb
   import obma_pkg::*;
   ;
   typedef struct packed {
      logic [1:0] kind;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic [3:0] waits;
      logic [1:0] err;
      logic [15:0] rdata;
   } obma_row_t;
   logic clock, reset_n, req_valid, req_operand, req_more, other_busy, req_ready;
   logic [1:0] req_kind, err;
   logic [3:0] waits;
   logic [15:0] req_addr, req_wdata, data_in, data_out, addr_out, rdata_q;
   logic done_pulse, error_pulse, bus_req_out_n, bus_grant_in_n, bus_busy_in_n;
   logic grant_ack_out_n, grant_ack_oe, fetch_phase_out, addr_strobe_n, data_strobe_n;
   logic rd_wr_n, mem_io_n, operand_or_instr_sel, ctrl_oe, addr_oe, data_oe;
   logic xfer_ack_n, mem_protect_fault_n, bus_error_in_n;
   int bad_count, n_compared, n, c0;
   int req_cycles = 0;
   obma_row_t rows [6];
   obma_master DUT (.clock, .reset_n, .req_valid, .req_kind, .req_operand, .req_more,
      .req_addr, .req_wdata, .req_ready, .done_pulse, .error_pulse, .rdata_q,
      .bus_req_out_n, .bus_grant_in_n, .bus_busy_in_n, .grant_ack_out_n, .grant_ack_oe,
      .fetch_phase_out, .addr_strobe_n, .data_strobe_n, .rd_wr_n, .mem_io_n,
      .operand_or_instr_sel, .ctrl_oe, .addr_out, .addr_oe, .data_in, .data_out,
      .data_oe, .xfer_ack_n, .mem_protect_fault_n, .bus_error_in_n);
   obma_partner far_end (.clock, .reset_n, .waits, .err, .other_busy, .bus_req_out_n,
      .data_strobe_n, .rd_wr_n, .data_out, .bus_grant_in_n, .bus_busy_in_n, .xfer_ack_n,
      .mem_protect_fault_n, .bus_error_in_n, .data_in);
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock) if (bus_req_out_n === 1'b0) req_cycles++;
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task tick;
      @(posedge clock);
      #2;
   endtask
   task guard;
      tick();
      n++;
      if (n > 60) begin
         bad_count++;
         wrap_up();
      end
   endtask
   task issue(input obma_row_t r, input logic more);
      waits = r.waits;
      err = r.err;
      req_kind = r.kind;
      req_addr = r.addr;
      req_wdata = r.wdata;
      req_more = more;
      req_operand = r.kind[1];
      req_valid = 1'b1;
      tick();
      req_valid = 1'b0;
   endtask
   task finish_cycle(input obma_row_t r, input logic more);
      n = 0;
      while (addr_strobe_n !== 1'b0) guard();
      chk("addr_phase", {8'h1b, ~r.kind[0], ~r.kind[1], r.kind[1], r.kind[0], 1'b0},
         {fetch_phase_out, grant_ack_oe, grant_ack_out_n, ctrl_oe, addr_oe, rd_wr_n, mem_io_n,
         operand_or_instr_sel, data_oe, req_ready});
      chk("addr_out", r.addr, addr_out);
      @(posedge clock);
      @(negedge clock);
      #2;
      chk("data_strobe", 0, data_strobe_n);
      if (r.kind[0]) chk("wdata", r.wdata, data_out);
      n = 0;
      while (done_pulse !== 1'b1 && error_pulse !== 1'b1) guard();
      chk("latency", r.waits + 1, n);
      chk("end", {r.err == 0, r.err != 0, 2'h0},
         {done_pulse, error_pulse, addr_strobe_n, data_strobe_n});
      tick();
      chk("strobes_high", 4'h3,
         {done_pulse, error_pulse, addr_strobe_n, data_strobe_n});
      if (!r.kind[0] && r.err == 0) chk("rdata", r.rdata, rdata_q);
      tick();
      chk("release", {more, 3'h1},
         {grant_ack_oe, addr_oe, fetch_phase_out, req_ready});
   endtask
   initial begin
      {reset_n, req_valid, req_operand, req_more, other_busy, req_kind, err, waits} = '0;
      {req_addr, req_wdata, bad_count, n_compared} = '0;
      repeat (16) @(posedge clock);
      #2;
      chk("reset", 16'h0007, {addr_oe, data_oe, ctrl_oe, grant_ack_oe, fetch_phase_out,
         addr_strobe_n, data_strobe_n, bus_req_out_n});
      reset_n = 1'b1;
      rows = '{'{OBMA_MEM_WR, 16'h0010, 16'ha5c3, 4'h0, 2'h0, 16'h0000},
         '{OBMA_MEM_RD, 16'h0010, 16'h0000, 4'h1, 2'h0, 16'ha5c3},
         '{OBMA_IO_WR, 16'hff00, 16'h5a3c, 4'h0, 2'h0, 16'h0000},
         '{OBMA_IO_RD, 16'hff00, 16'h0000, 4'h3, 2'h0, 16'h5a3c},
         '{OBMA_MEM_RD, 16'h0020, 16'h0000, 4'h0, 2'h1, 16'h0000},
         '{OBMA_IO_WR, 16'h0030, 16'h0f0f, 4'h2, 2'h2, 16'h0000}};
      foreach (rows[i]) begin
         c0 = req_cycles;
         issue(rows[i], 1'b0);
         finish_cycle(rows[i], 1'b0);
         chk("requested", 1, req_cycles > c0);
         tick();
      end
      // another master holds the bus for nine cycles
      other_busy = 1'b1;
      issue(rows[3], 1'b0);
      repeat (8) tick();
      chk("busy_wait", 2'h2, {addr_strobe_n, bus_req_out_n});
      other_busy = 1'b0;
      finish_cycle(rows[3], 1'b0);
      tick();
      // back-to-back cycles keep ownership without a new request
      issue(rows[2], 1'b1);
      finish_cycle(rows[2], 1'b1);
      c0 = req_cycles;
      issue(rows[1], 1'b0);
      finish_cycle('{OBMA_MEM_RD, 16'h0010, 16'h0000, 4'h1, 2'h0, 16'h5a3c}, 1'b0);
      chk("no_new_req", c0, req_cycles);
      // reset in mid-cycle floats the bus at once and leaves it idle
      issue(rows[0], 1'b1);
      n = 0;
      while (addr_strobe_n !== 1'b0) guard();
      reset_n = 1'b0;
      tick();
      chk("mid_reset", 16'h0007, {addr_oe, data_oe, ctrl_oe, grant_ack_oe, fetch_phase_out,
         addr_strobe_n, data_strobe_n, bus_req_out_n});
      reset_n = 1'b1;
      repeat (2) tick();
      chk("after_reset", 16'h0007, {addr_oe, data_oe, ctrl_oe, grant_ack_oe, fetch_phase_out,
         addr_strobe_n, data_strobe_n, bus_req_out_n});
      wrap_up();
   end
endmodule
`default_nettype wire
